// >>> logic/vcr_pkg.sv
// Constants and carrier types for the oscillator and output synthesizer control bank.
package vcr_pkg;

    // ------------------------------------------------------------------
    // Serial port framing
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 13;
    localparam int          INSTR_BITS  = 16;
    localparam int          FRAME_BITS  = 24;
    localparam logic [4:0]  CNT_ADDR    = 5'h0f;
    localparam logic [4:0]  CNT_DATA    = 5'h10;
    localparam logic [4:0]  CNT_LAST    = 5'h17;
    localparam logic [4:0]  CNT_END     = 5'h18;
    localparam int          RD_FLAG_POS = 14;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [12:0] REG_CAL     = 13'h000e;
    localparam logic [12:0] REG_AMP     = 13'h000f;
    localparam logic [12:0] REG_BAND    = 13'h0010;
    localparam logic [12:0] REG_INT     = 13'h0011;
    localparam logic [12:0] REG_MOD_HI  = 13'h0012;
    localparam logic [12:0] REG_MOD_MID = 13'h0013;
    localparam logic [12:0] REG_MOD_LO  = 13'h0014;
    localparam logic [12:0] REG_FRACTION_HIGH_BYTE_HI = 13'h0015;
    localparam logic [12:0] REG_FRACTION_HIGH_BYTE_MID= 13'h0016;
    localparam logic [12:0] REG_FRACTION_HIGH_BYTE_LO = 13'h0017;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CAL_GO_BIT   = 7;
    localparam int ALC_EN_BIT   = 6;
    localparam int THR_HI       = 5;
    localparam int THR_LO       = 3;
    localparam int SW_CAL_BIT   = 2;
    localparam int BOOST_BIT    = 1;
    localparam int BAND_SW_BIT  = 0;
    localparam int AMP_HI       = 7;
    localparam int AMP_LO       = 2;
    localparam int BAND_HI      = 7;
    localparam int BAND_LO      = 1;
    localparam int NIB_HI       = 7;
    localparam int NIB_LO       = 4;
    localparam int SPI_FREQ_BIT = 3;
    localparam int BYPASS_BIT   = 2;
    localparam int MODULATOR_OFF_BIT = 1;
    localparam int SYN_RST_BIT  = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CAL      = 8'h70;
    localparam logic [7:0] RST_AMP      = 8'h00;
    localparam logic [7:0] RST_BAND     = 8'h80;
    localparam logic [7:0] RST_INT      = 8'h00;
    localparam logic [7:0] RST_MOD_HI   = 8'h80;
    localparam logic [7:0] RST_MOD_MID  = 8'h00;
    localparam logic [7:0] RST_MOD_LO   = 8'h00;
    localparam logic [7:0] RST_FRACTION_HIGH_BYTE_HI  = 8'h20;
    localparam logic [7:0] RST_FRACTION_HIGH_BYTE_MID = 8'h00;
    localparam logic [7:0] RST_FRACTION_HIGH_BYTE_LO  = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          CAL_TIME_NS   = 20000;
    localparam logic [15:0] CAL_CYCLES    =
        16'((CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        CAL_IDLE = 1'b0,
        CAL_RUN  = 1'b1
    } vcr_cal_state_t;

    typedef struct packed {
        logic        wr;
        logic [12:0] addr;
        logic [7:0]  data;
    } vcr_bus_t;

    typedef struct packed {
        logic        cal_start;
        logic        cal_busy;
        logic        boost;
        logic        thr_auto;
        logic [2:0]  threshold;
        logic [5:0]  level;
        logic [6:0]  band;
    } vcr_vco_t;

    typedef struct packed {
        logic        from_regs;
        logic [3:0]  pin_rate;
        logic [7:0]  int_div;
        logic [19:0] modulus_value;
        logic [19:0] fractional_value;
        logic        modulator_clk_en;
        logic        synth_rst;
    } vcr_synth_t;

endpackage

// >>> logic/vcr_serial_port.sv
// Three-wire serial port: one 16-bit instruction and one data byte per frame.
`timescale 1ns/1ns
`default_nettype none
module vcr_serial_port
    import vcr_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire logic     sclk,
    input  wire logic     csb_n,
    input  wire logic     sdio_in,
    output logic          sdio_out,
    output logic          sdio_oe,
    output var vcr_bus_t  bus,
    input  wire logic [7:0] rd_data
);
    logic        sclk_q;
    logic [4:0]  cnt;
    logic [15:0] shift;
    logic        rd;
    logic        wr;
    logic [12:0] addr;
    logic [7:0]  data;

    wire  sclk_rise = sclk & ~sclk_q;
    wire  sclk_fall = ~sclk & sclk_q;
    wire  [2:0] out_idx = 3'(CNT_LAST - cnt);

    assign bus = '{wr: wr, addr: addr, data: data};

    // ------------------------------------------------------------------
    // Shift in on rising edges, drive read data on falling edges
    // ------------------------------------------------------------------
    // Read data changes on the falling edge so the master samples it
    // stable on the next rising edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q   <= 1'b0;
            cnt      <= 5'h00;
            shift    <= 16'h0000;
            rd       <= 1'b0;
            wr       <= 1'b0;
            addr     <= 13'h0000;
            data     <= 8'h00;
            sdio_out <= 1'b0;
            sdio_oe  <= 1'b0;
        end else begin
            sclk_q <= sclk;
            wr     <= 1'b0;
            if (csb_n) begin
                cnt     <= 5'h00;
                sdio_oe <= 1'b0;
            end else if (sclk_rise && cnt < CNT_END) begin
                shift <= {shift[14:0], sdio_in};
                cnt   <= cnt + 5'h01;
                if (cnt == CNT_ADDR) begin
                    rd   <= shift[RD_FLAG_POS];
                    addr <= {shift[11:0], sdio_in};
                end
                if (cnt == CNT_LAST && !rd) begin
                    data <= {shift[6:0], sdio_in};
                    wr   <= 1'b1;
                end
            end else if (sclk_fall && rd && cnt >= CNT_DATA && cnt <= CNT_LAST) begin
                sdio_out <= rd_data[out_idx];
                sdio_oe  <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// >>> logic/vcr_ctrl_regs.sv
// Oscillator and output synthesizer control register bank behind the serial port.
// Function
// - Writing one to calibrate bit starts calibration; bit clears itself when done.
// - Calibrate bit is ignored unless software calibration enable is set.
// - With software enable clear, calibration runs automatically; otherwise only on request.
// - Level control enable selects automatic level and threshold; else level field sets the level.
// - Threshold field resets to 110; middle bit inverted sense.
// - Band source bit selects automatic band or the 7-bit band field.
// - Amplitude field spans six bits; two low bits unused.
// - Band field spans seven bits, resets to 100 0000; bit zero unused.
// - Integer divide register holds eight bits, reset 0x00.
// - Modulus split across high, middle and upper nibble of low register.
// - Modulus resets to 524,288.
// - Frequency source bit selects rate pins or registers.
// - Bypass bit clear permits integer-plus-fractional division.
// - Modulator disable bit stops modulator clocks.
// - Synthesizer reset bit holds counters and logic in reset.
// - Fraction high register holds bits 19 to 12.
// - Remaining fraction bits in next two registers; fraction resets to 131,072.
`timescale 1ns/1ns
`default_nettype none
module vcr_ctrl_regs
    import vcr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sclk,
    input  wire logic        csb_n,
    input  wire logic        sdio_in,
    output logic             sdio_out,
    output logic             sdio_oe,
    input  wire logic [3:0]  rate_pins,
    input  wire logic [5:0]  auto_level,
    input  wire logic [6:0]  auto_band,
    output var vcr_vco_t     vco,
    output var vcr_synth_t   synth
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    vcr_bus_t       bus;
    logic [7:0]     rd_data;
    logic [7:0]     cal_reg;
    logic [7:0]     amp_reg;
    logic [7:0]     band_reg;
    logic [7:0]     int_reg;
    logic [7:0]     mod_hi;
    logic [7:0]     mod_mid;
    logic [7:0]     mod_lo;
    logic [7:0]     fraction_high_byte_hi;
    logic [7:0]     fraction_high_byte_mid;
    logic [7:0]     fraction_high_byte_lo;
    vcr_cal_state_t cal_state;
    logic [15:0]    cal_cnt;
    logic           auto_pend;
    logic           cal_start;

    function automatic logic hit(input logic [12:0] a, input logic [12:0] r);
        hit = (a == r);
    endfunction

    vcr_serial_port u_port (
        .clk      (clk),
        .rst_n    (rst_n),
        .sclk     (sclk),
        .csb_n    (csb_n),
        .sdio_in  (sdio_in),
        .sdio_out (sdio_out),
        .sdio_oe  (sdio_oe),
        .bus      (bus),
        .rd_data  (rd_data)
    );

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire wr_cal      = bus.wr & hit(bus.addr, REG_CAL);
    wire wr_amp      = bus.wr & hit(bus.addr, REG_AMP);
    wire wr_band     = bus.wr & hit(bus.addr, REG_BAND);
    wire wr_int      = bus.wr & hit(bus.addr, REG_INT);
    wire wr_mod_hi   = bus.wr & hit(bus.addr, REG_MOD_HI);
    wire wr_mod_mid  = bus.wr & hit(bus.addr, REG_MOD_MID);
    wire wr_mod_lo   = bus.wr & hit(bus.addr, REG_MOD_LO);
    wire wr_fraction_high_byte_hi  = bus.wr & hit(bus.addr, REG_FRACTION_HIGH_BYTE_HI);
    wire wr_fraction_high_byte_mid = bus.wr & hit(bus.addr, REG_FRACTION_HIGH_BYTE_MID);
    wire wr_fraction_high_byte_lo  = bus.wr & hit(bus.addr, REG_FRACTION_HIGH_BYTE_LO);

    wire sw_cal_en   = cal_reg[SW_CAL_BIT];
    // The enable written in the same byte counts, so one write can both
    // hand calibration to software and fire it.
    wire cal_go_wr   = wr_cal & bus.data[CAL_GO_BIT] & bus.data[SW_CAL_BIT];
    // Any change to band or frequency setup warrants a fresh automatic run.
    wire cfg_change  = wr_band | wr_int | wr_mod_hi | wr_mod_mid | wr_mod_lo
                     | wr_fraction_high_byte_hi | wr_fraction_high_byte_mid | wr_fraction_high_byte_lo;
    wire cal_want    = cal_reg[CAL_GO_BIT] | (auto_pend & ~sw_cal_en);
    wire cal_done    = (cal_state == CAL_RUN) && (cal_cnt == 16'h0001);

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_reg  <= RST_CAL;
            amp_reg  <= RST_AMP;
            band_reg <= RST_BAND;
            int_reg  <= RST_INT;
            mod_hi   <= RST_MOD_HI;
            mod_mid  <= RST_MOD_MID;
            mod_lo   <= RST_MOD_LO;
            fraction_high_byte_hi  <= RST_FRACTION_HIGH_BYTE_HI;
            fraction_high_byte_mid <= RST_FRACTION_HIGH_BYTE_MID;
            fraction_high_byte_lo  <= RST_FRACTION_HIGH_BYTE_LO;
        end else begin
            if (wr_cal) begin
                cal_reg[6:0] <= bus.data[6:0];
            end
            // Self-clearing go bit; a new request in the finishing cycle wins.
            // Dropping the enable in a write also drops a request not yet served.
            if (cal_go_wr) begin
                cal_reg[CAL_GO_BIT] <= 1'b1;
            end else if (cal_done || !sw_cal_en || (wr_cal && !bus.data[SW_CAL_BIT])) begin
                cal_reg[CAL_GO_BIT] <= 1'b0;
            end
            if (wr_amp) begin
                amp_reg <= {bus.data[AMP_HI:AMP_LO], 2'b00};
            end
            if (wr_band) begin
                band_reg <= {bus.data[BAND_HI:BAND_LO], 1'b0};
            end
            if (wr_int) begin
                int_reg <= bus.data;
            end
            if (wr_mod_hi) begin
                mod_hi <= bus.data;
            end
            if (wr_mod_mid) begin
                mod_mid <= bus.data;
            end
            if (wr_mod_lo) begin
                mod_lo <= bus.data;
            end
            if (wr_fraction_high_byte_hi) begin
                fraction_high_byte_hi <= bus.data;
            end
            if (wr_fraction_high_byte_mid) begin
                fraction_high_byte_mid <= bus.data;
            end
            if (wr_fraction_high_byte_lo) begin
                fraction_high_byte_lo <= {bus.data[NIB_HI:NIB_LO], 4'h0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------------
    // Pending starts set at reset so the oscillator is calibrated once
    // after power-up when the device owns calibration.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_state <= CAL_IDLE;
            cal_cnt   <= 16'h0000;
            auto_pend <= 1'b1;
            cal_start <= 1'b0;
        end else begin
            cal_start <= 1'b0;
            if (cfg_change && !sw_cal_en) begin
                auto_pend <= 1'b1;
            end else if (cal_state == CAL_IDLE && cal_want) begin
                auto_pend <= 1'b0;
            end
            unique case (cal_state)
                CAL_IDLE: begin
                    if (cal_want) begin
                        cal_state <= CAL_RUN;
                        cal_cnt   <= CAL_CYCLES;
                        cal_start <= 1'b1;
                    end
                end
                CAL_RUN: begin
                    cal_cnt <= cal_cnt - 16'h0001;
                    if (cal_done) begin
                        cal_state <= CAL_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs toward the oscillator and synthesizer
    // ------------------------------------------------------------------
    wire       bypass   = mod_lo[BYPASS_BIT];
    wire [5:0] amp_fld  = amp_reg[AMP_HI:AMP_LO];
    wire [6:0] band_fld = band_reg[BAND_HI:BAND_LO];

    assign vco.cal_start = cal_start;
    assign vco.cal_busy  = (cal_state == CAL_RUN);
    assign vco.boost     = cal_reg[BOOST_BIT];
    assign vco.thr_auto  = cal_reg[ALC_EN_BIT];
    // Threshold code passes raw; the detector applies the inverted middle bit.
    assign vco.threshold = cal_reg[THR_HI:THR_LO];
    assign vco.level     = cal_reg[ALC_EN_BIT] ? auto_level : amp_fld;
    assign vco.band      = cal_reg[BAND_SW_BIT] ? band_fld : auto_band;

    assign synth.from_regs        = mod_lo[SPI_FREQ_BIT];
    assign synth.pin_rate         = rate_pins;
    // Divide floor of 64 is left to software; the bank stores any value.
    assign synth.int_div          = int_reg;
    assign synth.modulus_value    = {mod_hi, mod_mid, mod_lo[NIB_HI:NIB_LO]};
    assign synth.fractional_value = bypass ? 20'h00000
                                  : {fraction_high_byte_hi, fraction_high_byte_mid, fraction_high_byte_lo[NIB_HI:NIB_LO]};
    assign synth.modulator_clk_en = ~mod_lo[MODULATOR_OFF_BIT];
    assign synth.synth_rst        = mod_lo[SYN_RST_BIT];

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 8'h00;
        if (hit(bus.addr, REG_CAL))      rd_data = cal_reg;
        if (hit(bus.addr, REG_AMP))      rd_data = amp_reg;
        if (hit(bus.addr, REG_BAND))     rd_data = band_reg;
        if (hit(bus.addr, REG_INT))      rd_data = int_reg;
        if (hit(bus.addr, REG_MOD_HI))   rd_data = mod_hi;
        if (hit(bus.addr, REG_MOD_MID))  rd_data = mod_mid;
        if (hit(bus.addr, REG_MOD_LO))   rd_data = mod_lo;
        if (hit(bus.addr, REG_FRACTION_HIGH_BYTE_HI))  rd_data = fraction_high_byte_hi;
        if (hit(bus.addr, REG_FRACTION_HIGH_BYTE_MID)) rd_data = fraction_high_byte_mid;
        if (hit(bus.addr, REG_FRACTION_HIGH_BYTE_LO))  rd_data = fraction_high_byte_lo;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_go_written;
        cal_go_wr && cal_state == CAL_IDLE && !cal_reg[CAL_GO_BIT];
    endsequence
    sequence s_run_to_idle;
        vco.cal_busy ##[1:300] !vco.cal_busy;
    endsequence

    a_cal_go_runs: assert property (s_go_written |=> cal_reg[CAL_GO_BIT] ##1 s_run_to_idle)
        else $error("calibrate request did not run");
    a_cal_self_clear: assert property ($fell(vco.cal_busy) && !$past(cal_go_wr)
            |-> !cal_reg[CAL_GO_BIT])
        else $error("calibrate bit did not clear");
    a_cal_go_ignored: assert property (wr_cal && !bus.data[SW_CAL_BIT]
            |=> !cal_reg[CAL_GO_BIT])
        else $error("calibrate bit took effect without enable");
    a_auto_cal_start: assert property (cfg_change && !sw_cal_en && !vco.cal_busy
            |-> ##[1:2] vco.cal_start)
        else $error("automatic calibration did not start");
    a_level_select: assert property (!cal_reg[ALC_EN_BIT] |-> vco.level == amp_fld)
        else $error("level field not applied");
    a_band_select: assert property (cal_reg[BAND_SW_BIT] == 1'b0 |-> vco.band == auto_band)
        else $error("automatic band not applied");
    a_band_write: assert property (wr_band |=> band_fld == $past(bus.data[BAND_HI:BAND_LO]))
        else $error("band field write lost");
    a_bypass_fraction_high_byte: assert property (bypass |-> synth.fractional_value == 20'h00000)
        else $error("fraction present during bypass");
    a_modulator_clock: assert property (wr_mod_lo |=>
            synth.modulator_clk_en == !$past(bus.data[MODULATOR_OFF_BIT]))
        else $error("modulator clock gate wrong");
    a_synth_reset: assert property (wr_mod_lo |=> synth.synth_rst == $past(bus.data[SYN_RST_BIT]))
        else $error("synthesizer reset wrong");

    // ------------------------------------------------------------------
    // Field write checks
    // ------------------------------------------------------------------
    // Each byte acts alone on write; these catch a lane or field that
    // lands in the wrong place of the value handed to the analog side.
    a_amp_write: assert property (wr_amp |=> amp_fld == $past(bus.data[AMP_HI:AMP_LO]))
        else $error("amplitude field write lost");
    a_thr_write: assert property (wr_cal |=>
            vco.threshold == $past(bus.data[THR_HI:THR_LO]))
        else $error("threshold field write lost");
    a_level_auto: assert property (cal_reg[ALC_EN_BIT] |-> vco.level == auto_level)
        else $error("automatic level not applied");
    a_int_write: assert property (wr_int |=> synth.int_div == $past(bus.data))
        else $error("integer divide write lost");
    a_mod_hi_write: assert property (wr_mod_hi |=>
            synth.modulus_value[19:12] == $past(bus.data))
        else $error("modulus high byte misplaced");
    a_mod_mid_write: assert property (wr_mod_mid |=>
            synth.modulus_value[11:4] == $past(bus.data))
        else $error("modulus middle byte misplaced");
    a_freq_source: assert property (wr_mod_lo |=>
            synth.from_regs == $past(bus.data[SPI_FREQ_BIT]))
        else $error("frequency source select wrong");
    a_fraction_high_byte_hi_write: assert property (wr_fraction_high_byte_hi && !bypass |=>
            synth.fractional_value[19:12] == $past(bus.data))
        else $error("fraction high byte misplaced");
    a_fraction_high_byte_mid_write: assert property (wr_fraction_high_byte_mid && !bypass |=>
            synth.fractional_value[11:4] == $past(bus.data))
        else $error("fraction middle byte misplaced");
    a_cal_start_busy: assert property (vco.cal_start |-> vco.cal_busy)
        else $error("calibration start without busy");

endmodule
`default_nettype wire

// >>> sim/test_vcr_ctrl_regs.sv
// Self-checking testbench for the oscillator and output synthesizer control bank.
`timescale 1ns/1ns
`default_nettype none
module test_vcr_ctrl_regs
    import vcr_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n;
    logic       sclk;
    logic       csb_n;
    logic       sdio_in;
    logic       sdio_out;
    logic       sdio_oe;
    logic [3:0] rate_pins;
    logic [5:0] auto_level;
    logic [6:0] auto_band;
    vcr_vco_t   vco;
    vcr_synth_t synth;
    logic [7:0] mdl [0:255];
    int         err_count = 0;
    int         total_checks = 0;
    int         seed = 32'hde1c2461;

    always #50 clk = ~clk;

    vcr_ctrl_regs u_vcr_ctrl_regs (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csb_n(csb_n),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .rate_pins(rate_pins),
        .auto_level(auto_level), .auto_band(auto_band), .vco(vco), .synth(synth));

    // ------------------------------------------------------------------
    // Checking and serial frames
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Bits are set while sclk is low and read data is taken just before each rise.
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 2'b00, 5'h00, a, d};
        q = 8'h00;
        csb_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdio_in = f[i];
            sclk = 1'b0;
            repeat (3) @(negedge clk);
            if (i < 8)
                q[i] = sdio_out;
            sclk = 1'b1;
            repeat (3) @(negedge clk);
        end
        sclk = 1'b0;
        repeat (3) @(negedge clk);
        csb_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b0, a, d, q);
        if (a >= 8'h0e && a <= 8'h17)
            mdl[a] = d & (a == 8'h0f ? 8'hfc : a == 8'h10 ? 8'hfe : a == 8'h17 ? 8'hf0 :
                          (a == 8'h0e && !d[2]) ? 8'h7f : 8'hff);
    endtask

    task automatic rd(input logic [7:0] a);
        logic [7:0] q;
        xfer(1'b1, a, 8'h00, q);
        chk("read data", q, mdl[a]);
    endtask

    task automatic cmp_out();
        chk("level", vco.level, mdl[14][6] ? auto_level : mdl[15][7:2]);
        chk("band", vco.band, mdl[14][0] ? mdl[16][7:1] : auto_band);
        chk("osc ctl", {vco.thr_auto, vco.threshold, vco.boost},
            {mdl[14][6], mdl[14][5:3], mdl[14][1]});
        chk("int_div", synth.int_div, mdl[17]);
        chk("modulus", synth.modulus_value, {mdl[18], mdl[19], mdl[20][7:4]});
        chk("fraction", synth.fractional_value,
            mdl[20][2] ? 20'h0 : {mdl[21], mdl[22], mdl[23][7:4]});
        chk("synth ctl", {synth.from_regs, synth.modulator_clk_en, synth.synth_rst, synth.pin_rate},
            {mdl[20][3], ~mdl[20][1], mdl[20][0], rate_pins});
    endtask

    // A queued automatic run leaves one idle cycle between runs, so idle
    // must be seen several cycles in a row before the sequencer is free.
    task automatic wait_idle();
        int quiet;
        quiet = 0;
        for (int n = 0; n < 2000 && quiet < 3; n++) begin
            @(negedge clk);
            quiet = (vco.cal_busy === 1'b0) ? quiet + 1 : 0;
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        foreach (mdl[i])
            mdl[i] = 8'h00;
        mdl[14] = 8'h70;
        mdl[16] = 8'h80;
        mdl[18] = 8'h80;
        mdl[21] = 8'h20;
        {rst_n, sclk, csb_n, sdio_in} = 4'b0010;
        {rate_pins, auto_level, auto_band} = 17'h0a5a5;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("auto cal busy", vco.cal_busy, 1'b1);
        cmp_out();
        for (int i = 14; i < 24; i++)
            rd(8'(i));
        wr(8'h20, 8'ha5);
        rd(8'h20);
        rd(8'h0d);
        for (int k = 0; k < 30; k++) begin
            a = 8'(14 + ($unsigned($random(seed)) % 10));
            d = 8'($random(seed));
            if (a == 8'h0e)
                d = d & 8'h7b;
            if (a == 8'h11)
                d = d | 8'h40;
            {rate_pins, auto_level, auto_band} = 17'($random(seed));
            wr(a, d);
            cmp_out();
            rd(a);
        end
        wr(8'h14, 8'h04);
        cmp_out();
        wr(8'h14, 8'h00);
        cmp_out();
        wait_idle();
        wr(8'h0e, 8'hf0);
        chk("ignored go", vco.cal_busy, 1'b0);
        rd(8'h0e);
        wr(8'h0e, 8'hf4);
        chk("sw cal busy", vco.cal_busy, 1'b1);
        rd(8'h0e);
        repeat (250) @(negedge clk);
        mdl[14][7] = 1'b0;
        chk("cal done", vco.cal_busy, 1'b0);
        rd(8'h0e);
        end_of_test();
    end

    // A hang is cut well past the roughly 12000 cycles the sequence needs.
    initial begin
        #(100 * 60000);
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
